// >>> rtl/wpg_pkg.sv
// Package of constants and types for the word pattern generator
package wpg_pkg;
   // Word length limits and selector presets
   localparam int WPG_MAX_LEN = 16;
   localparam int WPG_MIN_LEN = 2;
   localparam int WPG_SHORT_LEN = 14;
   localparam int WPG_CHAIN_MAX = 7;
   localparam int WPG_CHAIN_BITS = WPG_MAX_LEN * WPG_CHAIN_MAX;
   localparam int WPG_POS_W = 4;
   localparam logic [WPG_POS_W-1:0] WPG_POS_RST = 4'h0;

   // Register map (byte addresses)
   localparam logic [7:0] WPG_OFS_PATTERN = 8'h00;
   localparam logic [7:0] WPG_OFS_CONFIG = 8'h04;
   localparam logic [7:0] WPG_OFS_STATUS = 8'h08;
   localparam logic [7:0] WPG_OFS_COUNT = 8'h0C;

   // Reset values and config field positions
   localparam logic [15:0] WPG_PATTERN_RST = 16'h0000;
   localparam logic [4:0] WPG_LEN_RST = 5'h10;
   localparam int WPG_CFG_LEN_LSB = 0;
   localparam int WPG_CFG_SHORT_BIT = 8;
   localparam int WPG_CFG_CHAIN_BIT = 9;
   localparam int WPG_CFG_EN_BIT = 10;

   // AHB transfer codes
   localparam logic [1:0] WPG_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] WPG_HSIZE_WORD = 3'h2;

   typedef struct packed {
      logic [4:0] len;
      logic short_sel;
      logic chain_mode;
      logic enable;
   } wpg_cfg_s;

   typedef struct packed {
      logic trig;
      logic sync;
      logic carry;
   } wpg_out_s;
endpackage : wpg_pkg

// >>> rtl/wpg_seq.sv
// Position counter and pulse selection for one word generator
module wpg_seq (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Settings
   input wire wpg_pkg::wpg_cfg_s cfg,
   input wire logic [wpg_pkg::WPG_MAX_LEN-1:0] pattern,
   // Stepping
   input wire logic step,
   // Results
   output wpg_pkg::wpg_out_s outs,
   output logic [wpg_pkg::WPG_POS_W-1:0] pos
);
   import wpg_pkg::*;

   logic [WPG_POS_W-1:0] pos_r;
   logic [WPG_POS_W-1:0] pos_nxt;
   logic [WPG_POS_W-1:0] last;
   logic [4:0] len_eff;

   // (RULE2) Short selector
   // (RULE3) Internal length
   always_comb begin
      len_eff = cfg.len;
      if (cfg.short_sel) begin
         len_eff = 5'(WPG_SHORT_LEN);
      end
      if (len_eff < 5'(WPG_MIN_LEN)) begin
         len_eff = 5'(WPG_MIN_LEN);
      end else if (len_eff > 5'(WPG_MAX_LEN)) begin
         len_eff = 5'(WPG_MAX_LEN);
      end
      last = 4'(len_eff - 5'd1);
   end

   // (RULE11) Ascending order
   // (RULE8) One step per clock
   always_comb begin
      pos_nxt = pos_r;
      if (step) begin
         pos_nxt = (pos_r >= last) ? WPG_POS_RST : pos_r + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pos_r <= WPG_POS_RST;
      end else begin
         pos_r <= pos_nxt;
      end
   end

   // (RULE7) Pulse on enabled bit
   // (RULE10) Sync at first position
   always_comb begin
      outs.trig = step & pattern[pos_r];
      outs.sync = step & (pos_r == WPG_POS_RST);
      outs.carry = step & (pos_r >= last);
   end
   assign pos = pos_r;
endmodule : wpg_seq

// >>> rtl/wpg_top.sv
// Word pattern generator with AHB-Lite register access
// Contract
// (RULE1) Sixteen positions by default, each with its own enable bit.
// (RULE2) A short selector cuts the word to fourteen positions.
// (RULE3) A length setting gives 2 to 16 positions, wrapping after the last.
// (RULE4) Up to seven modules chain, lengths summing to at most 112; chained lengths here multiply instead.
// (RULE5) One enabled bit at length N gives one pulse per N clock pulses.
// (RULE6) A scaler output clocking a second module multiplies the ratios.
// (RULE7) A trigger pulse appears only in periods whose bit is enabled.
// (RULE8) Each bit clock pulse advances one position.
// (RULE9) Word rate is the bit rate divided by the word length.
// (RULE10) A sync pulse marks every arrival at the first position.
// (RULE11) Position one comes first after wrap, then ascending order.
module wpg_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Bit clock and chain link
   input wire logic bit_clk,
   input wire logic chain_in,
   // Pulse outputs
   output logic word_out,
   output logic sync_out,
   output logic chain_out
);
   import wpg_pkg::*;

   logic [15:0] pattern_r;
   logic [15:0] pattern_nxt;
   wpg_cfg_s cfg_r;
   wpg_cfg_s cfg_nxt;
   logic wr_pend_r;
   logic wr_pend_nxt;
   logic [7:0] addr_r;
   logic [7:0] addr_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [15:0] words_r;
   logic [15:0] words_nxt;
   logic clk_d_r;
   logic word_r;
   logic sync_r;
   logic carry_r;
   logic step;
   logic addr_ok;
   wpg_out_s outs;
   logic [WPG_POS_W-1:0] pos;

   // Bus side: zero wait states, always OKAY
   assign addr_ok = hsel & hready & (htrans == WPG_HTRANS_NONSEQ);

   always_comb begin
      pattern_nxt = pattern_r;
      cfg_nxt = cfg_r;
      wr_pend_nxt = 1'b0;
      addr_nxt = addr_r;
      rdata_nxt = rdata_r;
      if (wr_pend_r) begin
         case (addr_r)
            WPG_OFS_PATTERN: begin
               // (RULE1) Bit enables
               pattern_nxt = hwdata[15:0];
            end
            WPG_OFS_CONFIG: begin
               cfg_nxt.len = hwdata[WPG_CFG_LEN_LSB +: 5];
               cfg_nxt.short_sel = hwdata[WPG_CFG_SHORT_BIT];
               cfg_nxt.chain_mode = hwdata[WPG_CFG_CHAIN_BIT];
               cfg_nxt.enable = hwdata[WPG_CFG_EN_BIT];
            end
            default: begin
               pattern_nxt = pattern_r;
            end
         endcase
      end
      if (addr_ok) begin
         addr_nxt = haddr[7:0];
         wr_pend_nxt = hwrite;
         case (haddr[7:0])
            WPG_OFS_PATTERN: rdata_nxt = {16'h0000, pattern_r};
            WPG_OFS_CONFIG: rdata_nxt = {21'h00_0000, cfg_r.enable,
               cfg_r.chain_mode, cfg_r.short_sel, 3'h0, cfg_r.len};
            WPG_OFS_STATUS: rdata_nxt = {28'h000_0000, pos};
            WPG_OFS_COUNT: rdata_nxt = {16'h0000, words_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Rising edge of the bit clock; in chain mode the previous module
   // wrapping is what steps this one, so the lengths multiply.
   // (RULE4) Chained stepping
   // (RULE6) Cascaded scaling
   always_comb begin
      step = cfg_r.enable
         & (cfg_r.chain_mode ? chain_in : (bit_clk & ~clk_d_r));
   end

   // (RULE9) Word counter
   always_comb begin
      words_nxt = outs.sync ? words_r + 16'h0001 : words_r;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pattern_r <= WPG_PATTERN_RST;
         cfg_r <= '{len: WPG_LEN_RST, short_sel: 1'b0, chain_mode: 1'b0,
                    enable: 1'b1};
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
         words_r <= 16'h0000;
         clk_d_r <= 1'b0;
         word_r <= 1'b0;
         sync_r <= 1'b0;
         carry_r <= 1'b0;
      end else begin
         pattern_r <= pattern_nxt;
         cfg_r <= cfg_nxt;
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         rdata_r <= rdata_nxt;
         words_r <= words_nxt;
         clk_d_r <= bit_clk;
         word_r <= outs.trig;
         sync_r <= outs.sync;
         carry_r <= outs.carry;
      end
   end

   assign hrdata = rdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // (RULE5) Scaler output
   assign word_out = word_r;
   assign sync_out = sync_r;
   assign chain_out = carry_r;

   wpg_seq u_seq (
      .clk_sys(clk_sys),
      .rst(rst),
      .cfg(cfg_r),
      .pattern(pattern_r),
      .step(step),
      .outs(outs),
      .pos(pos)
   );

   // (RULE7) Trigger only on enabled bit
   chk_trig_gate: assert property ( // (RULE7)
      @(posedge clk_sys) disable iff (rst)
      word_out |-> $past(pattern_r[pos]) && $past(step))
      else $error("trigger without enabled bit");
   // (RULE7) Enabled bit always triggers
   chk_trig_on: assert property ( // (RULE7)
      @(posedge clk_sys) disable iff (rst)
      $past(step) && $past(pattern_r[pos]) |-> word_out)
      else $error("enabled bit gave no trigger");
   // (RULE10) Sync follows first position
   chk_sync_pos: assert property ( // (RULE10)
      @(posedge clk_sys) disable iff (rst)
      sync_out |-> $past(pos) == WPG_POS_RST)
      else $error("sync not at first position");
   // (RULE10) Sync whatever the pattern
   chk_sync_first: assert property ( // (RULE10)
      @(posedge clk_sys) disable iff (rst)
      $past(step) && $past(pos) == WPG_POS_RST |-> sync_out)
      else $error("first position gave no sync");
   // (RULE11) Position advances by one
   chk_pos_step: assert property ( // (RULE11)
      @(posedge clk_sys) disable iff (rst)
      step && !outs.carry |=> pos == $past(pos) + 4'h1)
      else $error("position did not advance");
   // (RULE3) Wrap back to first position
   chk_pos_wrap: assert property ( // (RULE3)
      @(posedge clk_sys) disable iff (rst)
      step && outs.carry |=> pos == WPG_POS_RST)
      else $error("position did not wrap");
   // (RULE3) No wrap before the last position; a shortened
   // word may still be beyond its new end for one step
   chk_len_wrap: assert property ( // (RULE3)
      @(posedge clk_sys) disable iff (rst)
      chain_out && !$past(cfg_r.short_sel)
         && $past(cfg_r.len) inside {[5'h02:5'h10]}
      |-> $past(pos) >= 4'($past(cfg_r.len) - 5'h01))
      else $error("wrap before last position");
   // (RULE2) Short length wraps at fourteen
   chk_short_len: assert property ( // (RULE2)
      @(posedge clk_sys) disable iff (rst)
      cfg_r.short_sel && step |=> pos < 4'(WPG_SHORT_LEN))
      else $error("short word overran");
   // (RULE2) Short word reaches its last position
   chk_short_wrap: assert property ( // (RULE2)
      @(posedge clk_sys) disable iff (rst)
      chain_out && $past(cfg_r.short_sel)
      |-> $past(pos) >= 4'(WPG_SHORT_LEN - 1))
      else $error("short word wrapped early");
   // (RULE8) No step, no motion
   chk_hold_pos: assert property ( // (RULE8)
      @(posedge clk_sys) disable iff (rst)
      !step |=> pos == $past(pos))
      else $error("position moved without clock");
   // (RULE8) Each rising bit clock steps
   chk_rise_step: assert property ( // (RULE8)
      @(posedge clk_sys) disable iff (rst)
      cfg_r.enable && !cfg_r.chain_mode && $rose(bit_clk) |-> step)
      else $error("bit clock edge lost");
   // (RULE8) Disabled generator stays quiet
   chk_idle_quiet: assert property ( // (RULE8)
      @(posedge clk_sys) disable iff (rst)
      !cfg_r.enable |=> !word_out && !sync_out && !chain_out)
      else $error("pulse while disabled");
   // (RULE5) Carry coincides with sync next
   chk_carry_sync: assert property ( // (RULE5)
      @(posedge clk_sys) disable iff (rst)
      chain_out |-> pos == WPG_POS_RST)
      else $error("carry without wrap");
   // (RULE9) Word count on sync
   chk_word_cnt: assert property ( // (RULE9)
      @(posedge clk_sys) disable iff (rst)
      sync_out |-> words_r == $past(words_r) + 16'h0001)
      else $error("word count missed");
endmodule : wpg_top

// >>> verification/wpg_bit_src.sv
// Bit clock source model driving the generator's bit clock or chain input
module wpg_bit_src (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Control from the bench
   input wire logic go,
   input wire logic [7:0] n,
   input wire logic [3:0] gap,
   // Clock towards the generator
   output logic bit_clk,
   output logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] left_r;
   logic [3:0] wait_r;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         left_r <= 8'h00;
         wait_r <= 4'h0;
         bit_clk <= 1'b0;
      end else if (go) begin
         left_r <= n;
      end else if (wait_r != 4'h0) begin
         // Low for gap cycles between steps
         wait_r <= wait_r - 4'h1;
         bit_clk <= 1'b0;
      end else if (left_r != 8'h00) begin
         bit_clk <= 1'b1;
         left_r <= left_r - 8'h01;
         wait_r <= gap;
      end else begin
         bit_clk <= 1'b0;
      end
   end
   assign busy = (left_r != 8'h00) || bit_clk || (wait_r != 4'h0);
endmodule : wpg_bit_src

// >>> verification/tb_wpg_top.sv
// Self-checking testbench for the word pattern generator
module tb_wpg_top;
   timeunit 1ns;
   timeprecision 100ps;
   import wpg_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, word_out, sync_out, chain_out;
   logic go = 1'b0;
   logic use_chain = 1'b0;
   logic sel_b = 1'b0;
   logic word_out_b;
   logic acc = 1'b0;
   logic busy, src;
   logic [7:0] n_steps = 8'h00;
   logic [3:0] gap = 4'h1;
   logic [15:0] seq = 16'h0000;
   int nw = 0, ns = 0, nc = 0, bw, bs, bc;
   int nb = 0, bb;
   int err_count = 0, n_tests = 0;
   always #2 clk_sys = ~clk_sys;
   wpg_bit_src i_src (.clk_sys(clk_sys), .rst(rst), .go(go), .n(n_steps),
      .gap(gap), .bit_clk(src), .busy(busy));
   wpg_top i_dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel & ~sel_b),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(WPG_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .bit_clk(src & ~use_chain), .chain_in(src & use_chain),
      .word_out(word_out), .sync_out(sync_out), .chain_out(chain_out));
   // Second generator clocked by the first one's trigger output
   wpg_top i_dut_b (.clk_sys(clk_sys), .rst(rst), .hsel(hsel & sel_b),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(WPG_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(), .hreadyout(), .hresp(), .bit_clk(1'b0),
      .chain_in(word_out), .word_out(word_out_b), .sync_out(),
      .chain_out());
   // Pulse counts, and one trigger bit gathered per step
   always @(posedge clk_sys) begin
      nw <= nw + int'(word_out === 1'b1);
      ns <= ns + int'(sync_out === 1'b1);
      nc <= nc + int'(chain_out === 1'b1);
      nb <= nb + int'(word_out_b === 1'b1);
      if (src) begin
         seq <= {acc, seq[15:1]};
         acc <= word_out;
      end else begin
         acc <= acc | word_out;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= WPG_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
   endtask : bus
   task rd(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(hrdata, exp);
      chk(32'(hresp), 32'h0000_0000);
   endtask : rd
   task run(input logic [7:0] n, input logic [3:0] g);
      bw = nw;
      bs = ns;
      bc = nc;
      bb = nb;
      n_steps <= n;
      gap <= g;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk_sys);
      // Source never went idle: give up at once
      if (busy !== 1'b0) begin
         err_count++;
         stop_test();
      end
      repeat (3) @(posedge clk_sys);
   endtask : run
   task cnt(input int ew, input int es, input int ec);
      chk(32'(nw - bw), 32'(ew));
      chk(32'(ns - bs), 32'(es));
      chk(32'(nc - bc), 32'(ec));
   endtask : cnt
   task stop_test;
      $display("%0d checks, %0d mismatches", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   // Whole run needs under a thousand cycles
   initial begin
      #100us;
      err_count++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(32'(WPG_OFS_PATTERN), 32'h0000_0000);
      rd(32'(WPG_OFS_CONFIG), 32'h0000_0410);
      rd(32'(WPG_OFS_STATUS), 32'h0000_0000);
      rd(32'h0000_0010, 32'h0000_0000);
      $display("test reset done");
      bus(1'b1, 32'(WPG_OFS_PATTERN), 32'h0000_0001);
      run(8'd32, 4'h1);
      cnt(2, 2, 2);
      rd(32'(WPG_OFS_COUNT), 32'h0000_0002);
      $display("test divider done");
      bus(1'b1, 32'(WPG_OFS_PATTERN), 32'h0000_a5c3);
      // Gap long enough to gather each step's trigger
      run(8'd17, 4'h5);
      chk(32'(seq), 32'h0000_a5c3);
      run(8'd15, 4'h3);
      cnt(7, 0, 1);
      rd(32'(WPG_OFS_STATUS), 32'h0000_0000);
      $display("test pattern done");
      bus(1'b1, 32'(WPG_OFS_CONFIG), 32'h0000_0510);
      bus(1'b1, 32'(WPG_OFS_PATTERN), 32'h0000_6000);
      run(8'd28, 4'h2);
      cnt(2, 2, 2);
      $display("test short done");
      bus(1'b1, 32'(WPG_OFS_PATTERN), 32'h0000_0001);
      for (int k = 0; k < 3; k++) begin
         automatic int len = (k == 0) ? 2 : (k == 1) ? 11 : 16;
         bus(1'b1, 32'(WPG_OFS_CONFIG), 32'h0000_0400 | 32'(len));
         run(8'(3 * len), 4'h1);
         cnt(3, 3, 3);
      end
      $display("test lengths done");
      bus(1'b1, 32'(WPG_OFS_CONFIG), 32'h0000_000b);
      run(8'd5, 4'h1);
      cnt(0, 0, 0);
      rd(32'(WPG_OFS_STATUS), 32'h0000_0000);
      $display("test disable done");
      bus(1'b1, 32'(WPG_OFS_CONFIG), 32'h0000_060b);
      use_chain <= 1'b1;
      run(8'd22, 4'h2);
      cnt(2, 2, 2);
      $display("test chain done");
      // First stage divides by 3, second by 4: 24 clocks, 2 pulses
      use_chain <= 1'b0;
      bus(1'b1, 32'(WPG_OFS_CONFIG), 32'h0000_0403);
      sel_b <= 1'b1;
      bus(1'b1, 32'(WPG_OFS_PATTERN), 32'h0000_0001);
      bus(1'b1, 32'(WPG_OFS_CONFIG), 32'h0000_0604);
      sel_b <= 1'b0;
      run(8'd24, 4'h1);
      cnt(8, 8, 8);
      chk(32'(nb - bb), 32'h0000_0002);
      $display("test cascade done");
      stop_test();
   end
endmodule : tb_wpg_top
